// >>> design/rfcr_pkg.sv
// Package with register map, field layout, reset values and scaling for the radio config bank.
package rfcr_pkg;
   // ==========================================================================
   // Register offsets.
   localparam logic [5:0] OFS_NODE_ADDRESS = 6'h09;
   localparam logic [5:0] OFS_CHANNEL_NUMBER = 6'h0a;
   localparam logic [5:0] OFS_SYNTH_IF_CONTROL = 6'h0b;
   localparam logic [5:0] OFS_SYNTH_OFFSET_CONTROL = 6'h0c;
   localparam logic [5:0] OFS_CARRIER_WORD_HIGH = 6'h0d;
   localparam logic [5:0] OFS_CARRIER_WORD_MID = 6'h0e;
   localparam logic [5:0] OFS_CARRIER_WORD_LOW = 6'h0f;
   localparam logic [5:0] OFS_BANDWIDTH_RATE_EXP = 6'h10;
   localparam logic [5:0] OFS_RATE_MANTISSA = 6'h11;
   // ==========================================================================
   // Reset values.
   localparam logic [7:0] RST_NODE_ADDRESS = 8'h00;
   localparam logic [7:0] RST_CHANNEL_NUMBER = 8'h00;
   localparam logic [4:0] RST_IF_SETTING = 5'h0f;
   localparam logic [7:0] RST_CARRIER_WORD_OFFSET = 8'h00;
   localparam logic [5:0] RST_CARRIER_HIGH = 6'h1e;
   localparam logic [7:0] RST_CARRIER_MID = 8'hc4;
   localparam logic [7:0] RST_CARRIER_LOW = 8'hec;
   localparam logic [1:0] RST_BW_EXPONENT = 2'h2;
   localparam logic [1:0] RST_BW_MANTISSA = 2'h0;
   localparam logic [3:0] RST_RATE_EXPONENT = 4'hc;
   localparam logic [7:0] RST_RATE_MANTISSA = 8'h22;
   // ==========================================================================
   // Field positions inside the bandwidth and rate register.
   localparam int BW_EXP_LSB = 6;
   localparam int BW_MAN_LSB = 4;
   localparam int RATE_EXP_LSB = 0;
   // ==========================================================================
   // Address check modes and broadcast values.
   localparam logic [1:0] ACHK_NONE = 2'h0;
   localparam logic [1:0] ACHK_NO_BCAST = 2'h1;
   localparam logic [1:0] ACHK_BCAST_00 = 2'h2;
   localparam logic [1:0] ACHK_BCAST_ALL = 2'h3;
   localparam logic [7:0] BCAST_LOW = 8'h00;
   localparam logic [7:0] BCAST_HIGH = 8'hff;
   // ==========================================================================
   // Scaling shifts onto the carrier grid of crystal / 2^16; decimation base shift and mantissa bias.
   localparam int IF_TO_CARRIER_SHIFT = 6;
   localparam int OFS_TO_CARRIER_SHIFT = 2;
   localparam int BW_BASE_MUL_SHIFT = 3;
   localparam logic [2:0] BW_MAN_BIAS = 3'h4;

   // Whole state of the bank.
   typedef struct packed {
      logic [7:0] node_address;
      logic [7:0] channel_index;
      logic [4:0] if_setting;
      logic [7:0] signed_carrier_word_offset;
      logic [21:0] carrier_word;
      logic [1:0] bandwidth_exponent;
      logic [1:0] bandwidth_mantissa;
      logic [3:0] symbol_rate_exponent;
      logic [7:0] symbol_rate_mantissa;
      logic [7:0] rdata;
      logic addr_match;
      logic addr_done;
      logic [23:0] synth_word;
      logic [8:0] decim_ratio;
   } rfcr_state_t;
endpackage : rfcr_pkg

// >>> design/rfcr_regs.sv
// Radio frequency and symbol-rate configuration register bank with derived settings.
`timescale 1ns/1ps

module rfcr_regs
   import rfcr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic rx_mode,
   input wire logic [1:0] address_check_select,
   input wire logic rx_addr_valid,
   input wire logic [7:0] rx_addr_byte,
   output logic addr_match,
   output logic addr_done,
   output logic [7:0] node_address,
   output logic [7:0] channel_index,
   output logic [4:0] if_setting,
   output logic [7:0] signed_carrier_word_offset,
   output logic [23:0] carrier_word,
   output logic [23:0] synth_word,
   output logic [1:0] bandwidth_exponent,
   output logic [1:0] bandwidth_mantissa,
   output logic [8:0] decim_ratio,
   output logic [3:0] symbol_rate_exponent,
   output logic [8:0] symbol_rate_mantissa
);
   // ==========================================================================
   // State registers.
   rfcr_state_t s_q;
   rfcr_state_t s_d;
   logic [7:0] rd_mux;
   logic [23:0] sext_off;
   logic [23:0] if_term;

   // Read multiplexer; reserved bits and unmapped offsets read zero.
   always_comb begin
      unique case (reg_addr)
         OFS_NODE_ADDRESS: rd_mux = s_q.node_address;
         OFS_CHANNEL_NUMBER: rd_mux = s_q.channel_index;
         OFS_SYNTH_IF_CONTROL: rd_mux = {3'h0, s_q.if_setting};
         OFS_SYNTH_OFFSET_CONTROL: rd_mux = s_q.signed_carrier_word_offset;
         OFS_CARRIER_WORD_HIGH: rd_mux = {2'h0, s_q.carrier_word[21:16]};
         OFS_CARRIER_WORD_MID: rd_mux = s_q.carrier_word[15:8];
         OFS_CARRIER_WORD_LOW: rd_mux = s_q.carrier_word[7:0];
         OFS_BANDWIDTH_RATE_EXP: rd_mux = {s_q.bandwidth_exponent, s_q.bandwidth_mantissa,
                                           s_q.symbol_rate_exponent};
         OFS_RATE_MANTISSA: rd_mux = s_q.symbol_rate_mantissa;
         default: rd_mux = 8'h00;
      endcase
   end

   // Offset sign-extended onto the carrier grid; IF scaled likewise, used only in receive.
   assign sext_off = 24'({{16{s_q.signed_carrier_word_offset[7]}}, s_q.signed_carrier_word_offset}
                         << OFS_TO_CARRIER_SHIFT);
   assign if_term = rx_mode ? 24'({19'h0, s_q.if_setting} << IF_TO_CARRIER_SHIFT) : 24'h0;

   // Next-state logic: register writes, reads, address filter and derived words.
   always_comb begin
      s_d = s_q;
      s_d.addr_done = 1'b0;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_NODE_ADDRESS: s_d.node_address = reg_wdata;
            OFS_CHANNEL_NUMBER: s_d.channel_index = reg_wdata;
            OFS_SYNTH_IF_CONTROL: s_d.if_setting = reg_wdata[4:0];
            OFS_SYNTH_OFFSET_CONTROL: s_d.signed_carrier_word_offset = reg_wdata;
            OFS_CARRIER_WORD_HIGH: s_d.carrier_word[21:16] = reg_wdata[5:0];
            OFS_CARRIER_WORD_MID: s_d.carrier_word[15:8] = reg_wdata;
            OFS_CARRIER_WORD_LOW: s_d.carrier_word[7:0] = reg_wdata;
            OFS_BANDWIDTH_RATE_EXP: begin
               s_d.bandwidth_exponent = reg_wdata[BW_EXP_LSB +: 2];
               s_d.bandwidth_mantissa = reg_wdata[BW_MAN_LSB +: 2];
               s_d.symbol_rate_exponent = reg_wdata[RATE_EXP_LSB +: 4];
            end
            OFS_RATE_MANTISSA: s_d.symbol_rate_mantissa = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         s_d.rdata = rd_mux;
      end
      // Address filter verdict, one cycle after each received address byte.
      if (rx_addr_valid) begin
         s_d.addr_done = 1'b1;
         unique case (address_check_select)
            ACHK_NONE: s_d.addr_match = 1'b1;
            ACHK_NO_BCAST: s_d.addr_match = (rx_addr_byte == s_q.node_address);
            ACHK_BCAST_00: s_d.addr_match = (rx_addr_byte == s_q.node_address) ||
                                            (rx_addr_byte == BCAST_LOW);
            ACHK_BCAST_ALL: s_d.addr_match = (rx_addr_byte == s_q.node_address) ||
                                             (rx_addr_byte == BCAST_LOW) ||
                                             (rx_addr_byte == BCAST_HIGH);
         endcase
      end
      // Synth word: base plus offset, minus IF in receive; wraps at 24 bits.
      s_d.synth_word = {2'h0, s_q.carrier_word} + sext_off - if_term;
      s_d.decim_ratio = 9'(({6'h0, BW_MAN_BIAS} + {7'h0, s_q.bandwidth_mantissa})
                           << (BW_BASE_MUL_SHIFT + 32'(s_q.bandwidth_exponent)));
   end

   // State register; configuration fields keep their value until reset or a write, but rdata, addr_match, addr_done and derived words do not.
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
         s_q.node_address <= RST_NODE_ADDRESS;
         s_q.channel_index <= RST_CHANNEL_NUMBER;
         s_q.if_setting <= RST_IF_SETTING;
         s_q.signed_carrier_word_offset <= RST_CARRIER_WORD_OFFSET;
         s_q.carrier_word <= {RST_CARRIER_HIGH, RST_CARRIER_MID, RST_CARRIER_LOW};
         s_q.bandwidth_exponent <= RST_BW_EXPONENT;
         s_q.bandwidth_mantissa <= RST_BW_MANTISSA;
         s_q.symbol_rate_exponent <= RST_RATE_EXPONENT;
         s_q.symbol_rate_mantissa <= RST_RATE_MANTISSA;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // Outputs.
   assign reg_rdata = s_q.rdata;
   assign addr_match = s_q.addr_match;
   assign addr_done = s_q.addr_done;
   assign node_address = s_q.node_address;
   assign channel_index = s_q.channel_index;
   assign if_setting = s_q.if_setting;
   assign signed_carrier_word_offset = s_q.signed_carrier_word_offset;
   assign carrier_word = {2'h0, s_q.carrier_word};
   assign synth_word = s_q.synth_word;
   assign bandwidth_exponent = s_q.bandwidth_exponent;
   assign bandwidth_mantissa = s_q.bandwidth_mantissa;
   assign decim_ratio = s_q.decim_ratio;
   assign symbol_rate_exponent = s_q.symbol_rate_exponent;
   assign symbol_rate_mantissa = {1'b1, s_q.symbol_rate_mantissa};

   // ==========================================================================
   // Assertions.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_bcast_ff_accept: assert property (
      rx_addr_valid && address_check_select == ACHK_BCAST_ALL && rx_addr_byte == BCAST_HIGH
      |=> addr_match && addr_done) else $error("0xff broadcast not accepted");
   a_no_bcast_reject: assert property (
      rx_addr_valid && address_check_select == ACHK_NO_BCAST && rx_addr_byte != node_address
      |=> !addr_match) else $error("foreign address accepted");
   a_channel_index_write_hold: assert property (
      reg_wr && reg_addr == OFS_CHANNEL_NUMBER |=> channel_index == $past(reg_wdata))
      else $error("channel write lost");
   a_if_rsvd_zero: assert property (
      reg_rd && reg_addr == OFS_SYNTH_IF_CONTROL |=> reg_rdata[7:5] == 3'h0)
      else $error("IF reserved bits nonzero");
   // The synth word lags its inputs by one cycle, so it is held against the previous fields.
   a_synth_rx_sub: assert property (
      rx_mode |=> synth_word == 24'($past(carrier_word)
         + {{14{$past(signed_carrier_word_offset[7])}}, $past(signed_carrier_word_offset), 2'h0}
         - {13'h0, $past(if_setting), 6'h0})) else $error("synth word wrong in rx");
   a_high_bits_zero: assert property (
      reg_rd && reg_addr == OFS_CARRIER_WORD_HIGH |=> reg_rdata[7:6] == 2'h0)
      else $error("carrier top bits nonzero");
   a_rst_carrier: assert property (
      $past(rst) |-> carrier_word == 24'h1ec4ec) else $error("carrier reset wrong");
   a_decim_ratio: assert property (
      $stable(bandwidth_mantissa) && $stable(bandwidth_exponent)
      |=> decim_ratio == 9'((12'($past(bandwidth_mantissa)) + 12'h4)
                            << (3 + $past(bandwidth_exponent))))
      else $error("decimation ratio wrong");
   a_hidden_one: assert property (
      reg_wr && reg_addr == OFS_RATE_MANTISSA
      |=> symbol_rate_mantissa == {1'b1, $past(reg_wdata)})
      else $error("implied mantissa bit missing");
   a_rate_exp_write: assert property (
      reg_wr && reg_addr == OFS_BANDWIDTH_RATE_EXP ##1 !reg_wr [*2]
      |-> symbol_rate_exponent == $past(reg_wdata[3:0], 2)) else $error("rate exponent lost");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr > OFS_RATE_MANTISSA |=> reg_rdata == 8'h00)
      else $error("unmapped read nonzero");

   c_bcast_00: cover property (rx_addr_valid && address_check_select == ACHK_BCAST_00
                               && rx_addr_byte == BCAST_LOW ##1 addr_match);
   c_rx_synth: cover property (rx_mode && reg_wr && reg_addr == OFS_SYNTH_IF_CONTROL);
   c_write_read: cover property (reg_wr ##1 reg_rd && $past(reg_addr) == reg_addr);

   // Transmit synth word carries no IF term; field writes land one cycle later.
   a_synth_tx_plain: assert property (
      !rx_mode |=> synth_word == 24'($past(carrier_word)
         + {{14{$past(signed_carrier_word_offset[7])}}, $past(signed_carrier_word_offset), 2'h0}))
      else $error("synth word wrong in tx");
   a_if_write: assert property (
      reg_wr && reg_addr == OFS_SYNTH_IF_CONTROL |=> if_setting == $past(reg_wdata[4:0]))
      else $error("IF write lost");
   a_offset_write: assert property (
      reg_wr && reg_addr == OFS_SYNTH_OFFSET_CONTROL |=> signed_carrier_word_offset == $past(reg_wdata))
      else $error("offset write lost");
   a_high_write: assert property (
      reg_wr && reg_addr == OFS_CARRIER_WORD_HIGH
      |=> carrier_word[23:16] == {2'h0, $past(reg_wdata[5:0])})
      else $error("carrier high write wrong");
   a_bcast_00_accept: assert property (
      rx_addr_valid && address_check_select == ACHK_BCAST_00 && rx_addr_byte == BCAST_LOW
      |=> addr_match && addr_done) else $error("0x00 broadcast not accepted");
   a_field_hold: assert property (
      !reg_wr |=> $stable(node_address) && $stable(channel_index) && $stable(carrier_word))
      else $error("field changed without write");

   c_bcast_ff: cover property (rx_addr_valid && address_check_select == ACHK_BCAST_ALL
                               && rx_addr_byte == BCAST_HIGH ##1 addr_match);
   c_rate_exp_hold: cover property (reg_wr && reg_addr == OFS_BANDWIDTH_RATE_EXP
                                    ##1 !reg_wr [*2]);
endmodule : rfcr_regs

// >>> dv/rfcr_host.sv
// Host controller model that drives the parallel register strobe port.
`timescale 1ns/1ps
module rfcr_host (
   input wire logic mclk,
   output logic [5:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   // ==========================================================================
   // Idle port at time zero.
   initial begin
      reg_addr = 6'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // One access cycle, entered at a falling edge and held through the next rising edge.
   task automatic acc(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
   endtask : acc
endmodule : rfcr_host

// >>> dv/testbench.sv
// Self-checking bench for the radio frequency and rate register bank.
`timescale 1ns/1ps
module testbench;
   import rfcr_pkg::*;
   logic mclk, rst, rx_mode, rx_addr_valid, addr_match, addr_done, reg_wr, reg_rd, rd_q;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rx_addr_byte, node_address, channel_index;
   logic [7:0] signed_carrier_word_offset, node, b;
   logic [1:0] address_check_select, bandwidth_exponent, bandwidth_mantissa;
   logic [4:0] if_setting;
   logic [23:0] carrier_word, synth_word;
   logic [8:0] decim_ratio, symbol_rate_mantissa;
   logic [3:0] symbol_rate_exponent;
   logic [7:0] mdl [0:63];
   logic [7:0] rq[$];
   logic aq[$];
   int error_cnt = 0;
   int checks = 0;
   // ==========================================================================
   // Design, host model and clock.
   rfcr_regs i_dut (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .rx_mode, .address_check_select, .rx_addr_valid, .rx_addr_byte, .addr_match,
      .addr_done, .node_address, .channel_index, .if_setting, .signed_carrier_word_offset,
      .carrier_word, .synth_word, .bandwidth_exponent, .bandwidth_mantissa, .decim_ratio,
      .symbol_rate_exponent, .symbol_rate_mantissa);
   rfcr_host i_host (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ==========================================================================
   // Shared compare, verdict and access helpers.
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic idle;
      i_host.acc(1'b0, 1'b0, 6'($urandom), 8'($urandom));
   endtask : idle
   // A write updates the model under the writable-bit mask of its register.
   task automatic wreg(input logic [5:0] a, input logic [7:0] d);
      i_host.acc(1'b1, 1'b0, a, d);
      mdl[a] = d & (a == 6'h0b ? 8'h1f : a == 6'h0d ? 8'h3f : (a >= 6'h09 && a <= 6'h11) ? 8'hff : 8'h00);
   endtask : wreg
   task automatic rreg(input logic [5:0] a);
      rq.push_back(mdl[a]);
      i_host.acc(1'b0, 1'b1, a, 8'($urandom));
   endtask : rreg
   // Derived outputs against the register model.
   task automatic chk_der;
      logic [23:0] cw;
      cw = {mdl[13], mdl[14], mdl[15]};
      check(24'(node_address), 24'(mdl[9]));
      check(24'(if_setting), 24'(mdl[11][4:0]));
      check(24'(signed_carrier_word_offset), 24'(mdl[12]));
      check(24'({bandwidth_exponent, bandwidth_mantissa}), 24'(mdl[16][7:4]));
      check(carrier_word, cw);
      check(24'(channel_index), 24'(mdl[10]));
      check(24'(decim_ratio), 24'((9'd4 + mdl[16][5:4]) << (3 + mdl[16][7:6])));
      check(24'(symbol_rate_mantissa), {15'h0, 1'b1, mdl[17]});
      check(24'(symbol_rate_exponent), 24'(mdl[16][3:0]));
      check(synth_word, cw + {{14{mdl[12][7]}}, mdl[12], 2'b0}
         - (rx_mode ? {13'h0, mdl[11][4:0], 6'h0} : 24'h0));
   endtask : chk_der
   // ==========================================================================
   // Result watcher: a read answers one edge later, a filter verdict with its done pulse.
   always @(posedge mclk) rd_q <= reg_rd & ~rst;
   always @(negedge mclk) begin
      if (rd_q === 1'b1) check(24'(reg_rdata), 24'(rq.pop_front()));
      if (addr_done === 1'b1) begin
         check(24'(aq.size() != 0), 24'h1);
         check(24'(addr_match), 24'(aq.pop_front()));
      end
   end
   // Watchdog.
   initial begin
      repeat (3000) @(posedge mclk);
      error_cnt++;
      stop_test();
   end
   // ==========================================================================
   // Main sequence.
   initial begin
      rst = 1'b1;
      rx_mode = 1'b0;
      address_check_select = 2'h0;
      rx_addr_valid = 1'b0;
      rx_addr_byte = 8'h00;
      void'($urandom(32'h862ba031));
      for (int a = 0; a < 64; a++) mdl[a] = 8'h00;
      mdl[11] = 8'h0f;
      mdl[13] = 8'h1e;
      mdl[14] = 8'hc4;
      mdl[15] = 8'hec;
      mdl[16] = 8'h8c;
      mdl[17] = 8'h22;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      for (int a = 8; a < 19; a++) rreg(6'(a));
      idle();
      chk_der();
      $display("test reset values done");
      repeat (4) begin
         for (int a = 9; a < 18; a++) wreg(6'(a), 8'($urandom));
         wreg(6'h3f, 8'($urandom));
         wreg(6'h10, 8'($urandom));
         rx_mode = ~rx_mode;
         idle();
         idle();
         chk_der();
         for (int a = 8; a < 19; a++) rreg(6'(a));
      end
      $display("test random writes done");
      b = 8'($urandom);
      rq.push_back(mdl[10]);
      i_host.acc(1'b1, 1'b1, 6'h0a, b);
      mdl[10] = b;
      rreg(6'h0a);
      $display("test same cycle access done");
      node = 8'h01 + 8'($urandom_range(252));
      wreg(6'h09, node);
      idle();
      for (int m = 0; m < 4; m++) begin
         address_check_select = 2'(m);
         for (int k = 0; k < 4; k++) begin
            b = k == 0 ? node : k == 1 ? 8'h00 : k == 2 ? 8'hff : node + 8'h01;
            rx_addr_valid = 1'b1;
            rx_addr_byte = b;
            aq.push_back(m == 0 || b == node || (m >= 2 && b == 8'h00) || (m == 3 && b == 8'hff));
            @(negedge mclk);
         end
      end
      rx_addr_valid = 1'b0;
      repeat (3) idle();
      check(24'(rq.size() + aq.size()), 24'h0);
      $display("test address filter done");
      stop_test();
   end
endmodule : testbench
